// ===== mbo_defs.vh
`ifndef MBO_DEFS_VH
`define MBO_DEFS_VH

// filter path select encoding
`define MBO_PATH_BYPASS     2'h0

// gain code reserved value
`define MBO_GAIN_RSVD       3'h7
`define MBO_GAIN_W          7
`define MBO_GAIN_ONE        7'h01

// modulator clock phase counter (clk_sys / 4)
`define MBO_PH_SYNC         2'h3
`define MBO_PH_RISE         2'h2
`define MBO_PH_STEP         2'h1

// data valid delay after modulator clock rise, ns, and the clock period
`define MBO_T_MCD_NS        100
`define MBO_T_CLK_NS        10
`define MBO_MCD_CYC         (`MBO_T_MCD_NS / `MBO_T_CLK_NS)

// recovery and stability figures
`define MBO_LIN_READS       31
`define MBO_SETTLE_READS    62
`define MBO_SAT_EXIT_MOD    12
`define MBO_SYNC_STABLE_MOD 16
`define MBO_SAT_RUN         16

`define MBO_CNT_W           7
`define MBO_CNT_ONE         7'h01
`define MBO_CNT_ZERO        7'h00

// recovery tracker states
`define MBO_RS_IDLE         4'h1
`define MBO_RS_SAT          4'h2
`define MBO_RS_SETTLE       4'h4
`define MBO_RS_DONE         4'h8

`endif

// ===== mbo_density.v
`timescale 1ns/1ps
`include "mbo_defs.vh"

module mbo_density #(
	parameter WIN_LOG2 = 6
) (
	input  wire                clk_sys,
	input  wire                rst_n,
	input  wire                tick,
	input  wire                bit_in,
	output reg  [WIN_LOG2:0]   density_q,
	output reg                 done_q
);

	reg  [WIN_LOG2-1:0] pos_q;
	reg  [WIN_LOG2:0]   ones_q;
	wire [WIN_LOG2:0]   ones_d;
	wire                last;

	assign ones_d = ones_q + {{WIN_LOG2{1'b0}}, bit_in};
	assign last   = &pos_q;

	// ones count per window of 2**WIN_LOG2 samples, full scale near 90%
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			pos_q     <= {WIN_LOG2{1'b0}};
			ones_q    <= {(WIN_LOG2+1){1'b0}};
			density_q <= {(WIN_LOG2+1){1'b0}};
			done_q    <= 1'b0;
		end else begin
			done_q <= 1'b0;
			if (tick) begin
				pos_q <= pos_q + {{(WIN_LOG2-1){1'b0}}, 1'b1};
				if (last) begin
					density_q <= ones_d; // RULE12
					ones_q    <= {(WIN_LOG2+1){1'b0}};
					done_q    <= 1'b1;
				end else begin
					ones_q <= ones_d;
				end
			end
		end
	end

endmodule

// ===== mbo_filter_model.sv
`timescale 1ns/1ps
module mbo_filter_model (
	input  wire       mclk_o,
	input  wire       mclk_oe,
	input  wire       first_stage_o,
	input  wire       first_stage_oe,
	input  wire       second_stage_o,
	input  wire       second_stage_oe,
	output wire [2:0] pin_level,
	output reg  [1:0] bits_q,
	output integer    merged
);
	reg [4:0] a_q;
	reg [2:0] b_q;
	// released pins tied to mixed levels so a swapped bit shows up
	assign pin_level = {second_stage_oe ? second_stage_o : 1'b1, first_stage_oe ? first_stage_o : 1'b0,
		mclk_oe ? mclk_o : 1'b1};
	always @(posedge mclk_o) begin
		bits_q <= {second_stage_o, first_stage_o};
		a_q <= {a_q[3:0], first_stage_o};
		b_q <= {b_q[1:0], second_stage_o};
	end
	always @*
		merged = 3 * a_q[2] - 6 * a_q[3] + 4 * a_q[4] + 9 * (b_q[0] - 2 * b_q[1] + b_q[2]);
endmodule

// ===== mbo_modout.v
`timescale 1ns/1ps
`include "mbo_defs.vh"

// Summary of operation
// RULE1: gain codes 000..110 select 1 to 64
// RULE2: outside logic merges both bitstreams by formula
// RULE3: modulator output mode powers down filter
// RULE4: flag high while input exceeds full scale
// RULE5: flag sampled at half modulator rate
// RULE6: path select 00 makes pins outputs
// RULE7: otherwise pins are inputs, tied outside
// RULE8: modulator clock is master clock over four
// RULE9: sync captured on clock edge, resets phase
// RULE10: first rise three or five clocks after
// RULE11: two parallel bits per modulator clock
// RULE12: first stage ones density tracks input
// RULE13: overdrive recovery: 31 then 62 readings
// RULE14: saturation exit 12 cycles, then 62 conversions
// RULE15: data update after each modulator clock rise
// RULE16: stable bitstream within 16 modulator periods
// RULE17: flag drops at first clean half-rate sample
module mbo_modout #(
	parameter DENS_LOG2 = 6
) (
	input  wire                   clk_sys,
	input  wire                   rst_n,
	input  wire [2:0]             gain_select,
	input  wire [1:0]             filter_path_select,
	input  wire                   sync_in,
	input  wire                   overrange_cmp,
	input  wire                   first_stage_bit,
	input  wire                   second_stage_bit,
	input  wire                   conv_strobe,
	input  wire                   mclk_i,
	input  wire                   first_stage_i,
	input  wire                   second_stage_i,
	output reg                    mclk_o,
	output reg                    mclk_oe,
	output reg                    first_stage_o,
	output reg                    first_stage_oe,
	output reg                    second_stage_o,
	output reg                    second_stage_oe,
	output reg  [`MBO_GAIN_W-1:0] gain_value_q,
	output reg                    filter_enable_q,
	output reg                    overrange_flag,
	output reg                    stream_stable_q,
	output reg                    modulator_saturated_q,
	output reg                    sat_exit_late_q,
	output reg                    output_linear_q,
	output reg                    output_settled_q,
	output reg  [DENS_LOG2:0]     ones_density_q,
	output reg  [2:0]             pin_level_q
);

	localparam ST_IDLE   = `MBO_RS_IDLE;
	localparam ST_SAT    = `MBO_RS_SAT;
	localparam ST_SETTLE = `MBO_RS_SETTLE;
	localparam ST_DONE   = `MBO_RS_DONE;

	// two-flop synchronisers for every pin-side input
	// nothing but the second flop ever reads the first
	reg  [4:0] meta_q;
	reg  [4:0] sync_q;
	wire [4:0] raw_in;

	assign raw_in = {second_stage_i, first_stage_i, mclk_i, overrange_cmp, sync_in};

	always @(posedge clk_sys) begin
		if (!rst_n) begin
			meta_q <= 5'h00;
			sync_q <= 5'h00;
		end else begin
			meta_q <= raw_in;
			sync_q <= meta_q;
		end
	end

	wire sync_lvl = sync_q[0];
	wire ovr_lvl  = sync_q[1];
	wire [2:0] pin_lvl = sync_q[4:2];
	reg  sync_prev_q;
	wire sync_evt;

	assign sync_evt = sync_lvl & ~sync_prev_q;

	wire mod_mode = (filter_path_select == `MBO_PATH_BYPASS);

	// modulator clock divider; rises when the phase reaches two
	// tick_q marks the rise cycle; data and counters step one edge later
	reg  [1:0] phase_q;
	wire [1:0] phase_d;
	reg        tick_q;
	reg        half_q;

	assign phase_d = sync_evt ? `MBO_PH_SYNC : phase_q + `MBO_PH_STEP;

	always @(posedge clk_sys) begin
		if (!rst_n) begin
			sync_prev_q <= 1'b0;
			// reset enters the sync phase, so reset and sync give the same first rise
			phase_q     <= `MBO_PH_SYNC;
			tick_q      <= 1'b0;
			half_q      <= 1'b0;
			mclk_o      <= 1'b0;
		end else begin
			sync_prev_q <= sync_lvl;
			phase_q     <= phase_d; // RULE9
			// sync sets phase three, so rise comes three edges later
			mclk_o      <= phase_d[1] & ~sync_evt; // RULE8 RULE10
			tick_q      <= (phase_d == `MBO_PH_RISE); // RULE8
			if (sync_evt)
				half_q <= 1'b0;
			else if (tick_q)
				half_q <= ~half_q;
		end
	end

	// pin direction and filter power follow the path select
	// one cycle of lag: the pins turn together with the filter power
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			mclk_oe         <= 1'b0;
			first_stage_oe  <= 1'b0;
			second_stage_oe <= 1'b0;
			filter_enable_q <= 1'b1;
			pin_level_q     <= 3'h0;
		end else begin
			mclk_oe         <= mod_mode; // RULE6 RULE7
			first_stage_oe  <= mod_mode; // RULE6 RULE7
			second_stage_oe <= mod_mode; // RULE6 RULE7
			filter_enable_q <= ~mod_mode; // RULE3
			if (!mod_mode)
				pin_level_q <= pin_lvl; // RULE7
		end
	end

	// data change one clock after the modulator clock rise, inside 100 ns
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			first_stage_o  <= 1'b0;
			second_stage_o <= 1'b0;
		end else if (tick_q) begin
			first_stage_o  <= first_stage_bit; // RULE11 RULE15
			second_stage_o <= second_stage_bit; // RULE11 RULE15
		end
	end

	// stream considered stable a fixed number of modulator periods after sync
	// every new sync restarts the count, so a burst of syncs keeps it low
	reg [`MBO_CNT_W-1:0] stab_cnt_q;

	always @(posedge clk_sys) begin
		if (!rst_n) begin
			stab_cnt_q      <= `MBO_CNT_ZERO;
			stream_stable_q <= 1'b0;
		end else if (sync_evt) begin
			stab_cnt_q      <= `MBO_CNT_ZERO;
			stream_stable_q <= 1'b0;
		end else if (tick_q && !stream_stable_q) begin
			stab_cnt_q <= stab_cnt_q + `MBO_CNT_ONE;
			if (stab_cnt_q == `MBO_SYNC_STABLE_MOD - 1)
				stream_stable_q <= 1'b1; // RULE16
		end
	end

	// gain decode; the reserved code keeps the previous gain
	// holding avoids a step to an undefined gain while the code is rewritten
	always @(posedge clk_sys) begin
		if (!rst_n)
			gain_value_q <= `MBO_GAIN_ONE;
		else if (gain_select != `MBO_GAIN_RSVD)
			gain_value_q <= `MBO_GAIN_ONE << gain_select; // RULE1
	end

	// over-range flag: comparator level sampled every second modulator tick
	// the comparator threshold itself (100% +-2.5%) lives in the analog front end
	// a flag pulse therefore lasts at least one half-rate period, eight clocks
	wire half_tick = tick_q & half_q;

	always @(posedge clk_sys) begin
		if (!rst_n)
			overrange_flag <= 1'b0;
		else if (half_tick)
			overrange_flag <= ovr_lvl; // RULE4 RULE5 RULE17
	end

	// saturation: first stage stuck at one level for a long run
	// limitation: a long run of equal bits near full scale also reads as saturated
	reg [`MBO_CNT_W-1:0] run_cnt_q;
	reg                  last_bit_q;
	wire                 sat_now;

	assign sat_now = (run_cnt_q >= `MBO_SAT_RUN);

	always @(posedge clk_sys) begin
		if (!rst_n) begin
			run_cnt_q             <= `MBO_CNT_ZERO;
			last_bit_q            <= 1'b0;
			modulator_saturated_q <= 1'b0;
		end else if (tick_q) begin
			last_bit_q <= first_stage_bit;
			if (first_stage_bit != last_bit_q)
				run_cnt_q <= `MBO_CNT_ZERO;
			else if (!sat_now)
				run_cnt_q <= run_cnt_q + `MBO_CNT_ONE;
			modulator_saturated_q <= sat_now; // RULE14
		end
	end

	// recovery tracker: counts modulator ticks out of saturation, then readings
	reg  [3:0]            rs_q;
	reg  [3:0]            rs_d;
	reg  [`MBO_CNT_W-1:0] rcnt_q;
	reg                   flag_prev_q;
	wire                  flag_fall;
	wire                  lin_ready;

	assign flag_fall = flag_prev_q & ~overrange_flag;

	always @* begin
		rs_d = rs_q;
		case (rs_q)
			ST_IDLE: begin
				if (flag_fall)
					rs_d = modulator_saturated_q ? ST_SAT : ST_SETTLE;
			end
			ST_SAT: begin
				if (!modulator_saturated_q)
					rs_d = ST_SETTLE;
			end
			ST_SETTLE: begin
				if (rcnt_q == `MBO_SETTLE_READS)
					rs_d = ST_DONE;
			end
			ST_DONE: begin
				if (overrange_flag)
					rs_d = ST_IDLE;
			end
			default: begin
				rs_d = ST_IDLE;
			end
		endcase
		// a new over-range always restarts the recovery
		if (overrange_flag && rs_q != ST_DONE)
			rs_d = ST_IDLE;
	end

	// the tick count left over from saturation must not pass for readings
	assign lin_ready = (rs_q == ST_SETTLE) && (rs_d == ST_SETTLE) && (rcnt_q >= `MBO_LIN_READS);

	// one counter serves both phases: ticks in saturation, readings after it
	always @(posedge clk_sys) begin
		if (!rst_n)
			rcnt_q <= `MBO_CNT_ZERO;
		else if (rs_d != rs_q)
			rcnt_q <= `MBO_CNT_ZERO;
		else if (rs_q == ST_SAT && tick_q)
			rcnt_q <= rcnt_q + `MBO_CNT_ONE;
		else if (rs_q == ST_SETTLE && conv_strobe && filter_enable_q)
			rcnt_q <= rcnt_q + `MBO_CNT_ONE; // RULE3
	end

	// tracker state, sticky late flag and per-cycle recovery status
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			rs_q             <= ST_DONE;
			flag_prev_q      <= 1'b0;
			sat_exit_late_q  <= 1'b0;
			output_linear_q  <= 1'b1;
			output_settled_q <= 1'b1;
		end else begin
			flag_prev_q <= overrange_flag;
			rs_q        <= rs_d;
			// saturation must clear within 12 modulator cycles
			if (rs_q == ST_SAT && rcnt_q >= `MBO_SAT_EXIT_MOD)
				sat_exit_late_q <= 1'b1; // RULE14
			else if (rs_q == ST_IDLE)
				sat_exit_late_q <= 1'b0;
			output_linear_q  <= (rs_d == ST_DONE) || lin_ready; // RULE13
			output_settled_q <= (rs_d == ST_DONE); // RULE13 RULE14
		end
	end

	// ones density of the first-stage stream
	// limitation: the figure lags the input by up to one full window
	wire [DENS_LOG2:0] dens;
	wire               dens_done;

	mbo_density #(
		.WIN_LOG2 (DENS_LOG2)
	) u_dens (
		.clk_sys   (clk_sys),
		.rst_n     (rst_n),
		.tick      (tick_q),
		.bit_in    (first_stage_bit),
		.density_q (dens),
		.done_q    (dens_done)
	);

	always @(posedge clk_sys) begin
		if (!rst_n)
			ones_density_q <= {(DENS_LOG2+1){1'b0}};
		else if (dens_done)
			ones_density_q <= dens; // RULE12
	end

endmodule

// ===== mbo_modout_monitor.sv
`timescale 1ns/1ps
`include "mbo_defs.vh"
module mbo_modout_monitor (
	input wire       clk_sys,
	input wire       rst_n,
	input wire [2:0] gain_select,
	input wire [1:0] filter_path_select,
	input wire       sync_in,
	input wire       overrange_cmp,
	input wire       first_stage_bit,
	input wire       mclk_o,
	input wire       mclk_oe,
	input wire       first_stage_o,
	input wire       first_stage_oe,
	input wire       second_stage_oe,
	input wire [6:0] gain_value_q,
	input wire       filter_enable_q,
	input wire       overrange_flag
);
	// cycles since sync_in was last high; a sync may cut a modulator period short
	reg [3:0] quiet_q;
	always @(posedge clk_sys)
		quiet_q <= (sync_in || !rst_n) ? 4'h0 : quiet_q + {3'h0, quiet_q != 4'hf};
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	property p_oe_on; filter_path_select == 2'h0 |=> mclk_oe && first_stage_oe && second_stage_oe; endproperty
	a_oe_on: assert property (p_oe_on) else $error("pins not driven");
	property p_oe_off; filter_path_select != 2'h0 |=> !mclk_oe && !first_stage_oe && !second_stage_oe; endproperty
	a_oe_off: assert property (p_oe_off) else $error("pins driven");
	property p_filt; filter_path_select == 2'h0 |=> !filter_enable_q; endproperty
	a_filt: assert property (p_filt) else $error("filter on");
	property p_div; $rose(mclk_o) && quiet_q > 4'h8 |-> $past(mclk_o, 3) && !$past(mclk_o, 2); endproperty
	a_div: assert property (p_div) else $error("mclk period");
	property p_sync; $rose(sync_in) |-> ##3 !mclk_o [*3] ##1 mclk_o; endproperty
	a_sync: assert property (p_sync) else $error("sync phase");
	property p_cap; $rose(mclk_o) && first_stage_oe |=> first_stage_o == $past(first_stage_bit); endproperty
	a_cap: assert property (p_cap) else $error("data update");
	property p_flag_hi; overrange_cmp [*8] ##1 overrange_cmp [*7] |-> overrange_flag; endproperty
	a_flag_hi: assert property (p_flag_hi) else $error("flag low");
	property p_flag_lo; !overrange_cmp [*8] ##1 !overrange_cmp [*7] |-> !overrange_flag; endproperty
	a_flag_lo: assert property (p_flag_lo) else $error("flag high");
	property p_gain; gain_select != 3'h7 |=> gain_value_q == (`MBO_GAIN_ONE << $past(gain_select)); endproperty
	a_gain: assert property (p_gain) else $error("gain map");
endmodule

bind mbo_modout mbo_modout_monitor i_mon (
	.clk_sys(clk_sys), .rst_n(rst_n), .gain_select(gain_select), .filter_path_select(filter_path_select),
	.sync_in(sync_in), .overrange_cmp(overrange_cmp), .first_stage_bit(first_stage_bit), .mclk_o(mclk_o),
	.mclk_oe(mclk_oe), .first_stage_o(first_stage_o), .first_stage_oe(first_stage_oe),
	.second_stage_oe(second_stage_oe), .gain_value_q(gain_value_q), .filter_enable_q(filter_enable_q),
	.overrange_flag(overrange_flag)
);

// ===== mbo_modout_tb.sv
`timescale 1ns/1ps
module mbo_modout_tb;
	reg        clk_sys = 1'b0;
	reg        rst_n = 1'b0;
	reg  [2:0] gain_select = 3'h0;
	reg  [1:0] filter_path_select = 2'h1;
	reg        sync_in = 1'b0;
	reg        overrange_cmp = 1'b0;
	reg        first_stage_bit = 1'b0;
	reg        second_stage_bit = 1'b0;
	reg        conv_strobe = 1'b0;
	reg        dither = 1'b0;
	reg  [2:0] cyc = 3'h0;
	wire       mclk_o, mclk_oe, first_stage_o, first_stage_oe, second_stage_o, second_stage_oe;
	wire       filter_enable_q, overrange_flag, stream_stable_q, output_linear_q, output_settled_q;
	wire       modulator_saturated_q, sat_exit_late_q;
	wire [6:0] gain_value_q, ones_density_q;
	wire [2:0] pin_level_q, pin_level;
	wire [1:0] bits_q;
	integer    merged, errors = 0, check_count = 0, i;
	mbo_modout i_dut (
		.clk_sys(clk_sys), .rst_n(rst_n), .gain_select(gain_select), .filter_path_select(filter_path_select),
		.sync_in(sync_in), .overrange_cmp(overrange_cmp), .first_stage_bit(first_stage_bit),
		.second_stage_bit(second_stage_bit), .conv_strobe(conv_strobe), .mclk_i(pin_level[0]),
		.first_stage_i(pin_level[1]), .second_stage_i(pin_level[2]), .mclk_o(mclk_o), .mclk_oe(mclk_oe),
		.first_stage_o(first_stage_o), .first_stage_oe(first_stage_oe), .second_stage_o(second_stage_o),
		.second_stage_oe(second_stage_oe), .gain_value_q(gain_value_q), .filter_enable_q(filter_enable_q),
		.overrange_flag(overrange_flag), .stream_stable_q(stream_stable_q),
		.modulator_saturated_q(modulator_saturated_q), .sat_exit_late_q(sat_exit_late_q),
		.output_linear_q(output_linear_q), .output_settled_q(output_settled_q),
		.ones_density_q(ones_density_q), .pin_level_q(pin_level_q)
	);
	mbo_filter_model i_model (
		.mclk_o(mclk_o), .mclk_oe(mclk_oe), .first_stage_o(first_stage_o), .first_stage_oe(first_stage_oe),
		.second_stage_o(second_stage_o), .second_stage_oe(second_stage_oe), .pin_level(pin_level),
		.bits_q(bits_q), .merged(merged)
	);
	always #5 clk_sys = ~clk_sys;
	// period of eight clocks seen every fourth clock gives an alternating stream
	always @(negedge clk_sys) begin
		cyc <= cyc + 3'h1;
		if (dither)
			first_stage_bit <= cyc[2];
	end
	task tk(input integer k);
		repeat (k) @(negedge clk_sys);
	endtask
	task chk(input ok, input [79:0] msg);
		begin
			check_count = check_count + 1;
			if (ok !== 1'b1) begin
				errors = errors + 1;
				$display("[FAIL] %0t %0s", $time, msg);
			end
		end
	endtask
	task t_gain;
		begin
			for (i = 0; i < 8; i = i + 1) begin
				gain_select = i[2:0];
				tk(2);
				chk(gain_value_q === (7'h01 << i[2:0]) || i == 7 && gain_value_q === 7'h40, "gain");
			end
			$display("gain done");
		end
	endtask
	task t_mode;
		begin
			for (i = 3; i >= 0; i = i - 1) begin
				filter_path_select = i[1:0];
				tk(4);
				chk({mclk_oe, first_stage_oe, second_stage_oe} === {3{i == 0}}, "oe");
				chk(filter_enable_q === (i != 0), "filter");
				if (i != 0)
					chk(pin_level_q === 3'h5, "pins");
			end
			$display("mode done");
		end
	endtask
	task t_clk;
		begin
			sync_in = 1'b1;
			tk(4);
			sync_in = 1'b0;
			chk(mclk_o === 1'b0, "reset");
			tk(1);
			chk(mclk_o === 1'b0, "early");
			tk(1);
			chk(mclk_o === 1'b1, "rise");
			tk(2);
			chk(mclk_o === 1'b0 && stream_stable_q === 1'b0, "half");
			tk(2);
			chk(mclk_o === 1'b1, "period");
			tk(64);
			chk(stream_stable_q === 1'b1, "stable");
			$display("clock done");
		end
	endtask
	task t_data;
		begin
			for (i = 0; i < 4; i = i + 1) begin
				{second_stage_bit, first_stage_bit} = i[1:0];
				tk(28);
				chk(bits_q === i[1:0], "bits");
				chk(merged === (i & 1), "merge");
			end
			dither = 1'b1;
			tk(530);
			chk(ones_density_q === 7'h20, "density");
			$display("data done");
		end
	endtask
	task t_flag;
		begin
			filter_path_select = 2'h2;
			overrange_cmp = 1'b1;
			tk(20);
			chk(overrange_flag === 1'b1, "flag up");
			overrange_cmp = 1'b0;
			tk(20);
			chk(overrange_flag === 1'b0, "flag down");
			for (i = 1; i <= 62; i = i + 1) begin
				conv_strobe = 1'b1;
				tk(1);
				conv_strobe = 1'b0;
				tk(2);
				if (i == 30 || i == 31)
					chk(output_linear_q === (i == 31), "linear");
				if (i == 61 || i == 62)
					chk(output_settled_q === (i == 62), "settled");
			end
			$display("flag done");
		end
	endtask
	task t_sat;
		begin
			dither = 1'b0;
			tk(1);
			first_stage_bit = 1'b1;
			tk(90);
			chk(modulator_saturated_q === 1'b1, "sat");
			overrange_cmp = 1'b1;
			tk(20);
			overrange_cmp = 1'b0;
			tk(160);
			chk(sat_exit_late_q === 1'b1 && output_settled_q === 1'b0, "late");
			dither = 1'b1;
			tk(24);
			chk(modulator_saturated_q === 1'b0 && output_linear_q === 1'b0, "exit");
			for (i = 1; i <= 62; i = i + 1) begin
				conv_strobe = 1'b1;
				tk(1);
				conv_strobe = 1'b0;
				tk(2);
			end
			chk(output_settled_q === 1'b1 && sat_exit_late_q === 1'b1, "recover");
			$display("sat done");
		end
	endtask
	task print_verdict;
		begin
			$display("checks %0d errors %0d", check_count, errors);
			if (errors == 0 && check_count > 0)
				$display("[ PASS ]");
			else
				$display("[ FAIL ]");
			$finish;
		end
	endtask
	initial begin
		tk(12);
		rst_n = 1'b1;
		tk(3);
		t_gain;
		t_mode;
		t_clk;
		t_data;
		t_flag;
		t_sat;
		print_verdict;
	end
	initial begin
		#50000;
		errors = errors + 1;
		print_verdict;
	end
endmodule
